// file: dv/tlm_maint_properties.sv
// Concurrent checks on the ports of the translation buffer maintenance block.
`timescale 1ns/10ps
`include "tlm_defines.svh"

module tlm_maint_properties
  import tlm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire tlm_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic cp0_enable,
  input wire logic lookup_req,
  input wire logic [18:0] lookup_virtual_page_pair_number,
  input wire logic [7:0] lookup_address_space_id,
  input wire logic lookup_hit,
  input wire logic [`TLM_IDX_W-1:0] lookup_index,
  input wire logic cop_unusable,
  input wire logic machine_check
);
  // A command write naming one of the four operations, and the refused form of it.
  logic cmd_w;
  logic refused;
  // Only the low three bits of a command word select the operation.
  assign cmd_w = bus_req.wr && (bus_req.addr == `TLM_OFF_COMMAND)
    && (bus_req.wdata[2:0] >= 3'h1) && (bus_req.wdata[2:0] <= 3'h4);
  assign refused = cmd_w && !cp0_enable;

  // One clock domain, so clock and reset are given once for all checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_cu_raise: assert property (refused |=> cop_unusable)
    else $error("refused command gave no unusable pulse");
  chk_cu_cause: assert property (cop_unusable |-> $past(refused))
    else $error("unusable pulse without a refused command");
  chk_refused_quiet: assert property (refused |=> !machine_check)
    else $error("refused command raised machine check");
  chk_mc_cause: assert property (machine_check |-> $past(cmd_w && cp0_enable))
    else $error("machine check without an accepted command");
  chk_hit_cause: assert property (lookup_hit |-> $past(lookup_req))
    else $error("lookup hit without a request");
  chk_index_hold: assert property (!lookup_req |=> $stable(lookup_index))
    else $error("lookup index moved without a request");
  chk_status_cu: assert property (refused ##1 (bus_req.rd && bus_req.addr == `TLM_OFF_STATUS)
    |=> bus_rdata[`TLM_STAT_CU_BIT])
    else $error("status does not show the refused command");
endmodule // tlm_maint_properties

// file: dv/tlm_maint_test.sv
// Self-checking testbench for the translation buffer maintenance block.
`timescale 1ns/10ps
`include "tlm_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end

module tlm_maint_test
  import tlm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cp0_enable = 1'b1;
  logic lookup_req = 1'b0;
  logic [18:0] lookup_virtual_page_pair_number = 19'h0;
  logic [7:0] lookup_address_space_id = 8'h0;
  tlm_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  logic lookup_hit;
  logic [`TLM_IDX_W-1:0] lookup_index;
  logic cop_unusable;
  logic machine_check;
  logic cu_seen;
  logic mc_seen;
  logic [31:0] rv;
  int error_cnt = 0;
  int tests_run = 0;

  tlm_maint u_tlm_maint (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cp0_enable(cp0_enable), .lookup_req(lookup_req), .lookup_virtual_page_pair_number(lookup_virtual_page_pair_number),
    .lookup_address_space_id(lookup_address_space_id), .lookup_hit(lookup_hit), .lookup_index(lookup_index),
    .cop_unusable(cop_unusable), .machine_check(machine_check));

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  function automatic logic [31:0] hi_f(input logic [18:0] v, input logic [7:0] a);
    return {v, 5'h0, a};
  endfunction
  function automatic logic [31:0] lo_f(input logic [20:0] p, input logic [2:0] c,
    input logic d, input logic v, input logic g);
    return {5'h0, p, c, d, v, g};
  endfunction

  task close_out;
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Bus write and read; the strobe drops at the edge that takes it.
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = bus_rdata;
  endtask
  // Issue a command and catch the one-cycle exception pulses after it.
  task op(input logic [31:0] code);
    wr(`TLM_OFF_COMMAND, code);
    @(negedge clk);
    cu_seen = cop_unusable;
    mc_seen = machine_check;
  endtask
  task put(input logic [4:0] i, input logic [31:0] h, input logic [31:0] l0,
    input logic [31:0] l1, input logic [31:0] m);
    wr(`TLM_OFF_INDEX, {27'h0, i});
    wr(`TLM_OFF_ENTRY_HIGH, h);
    wr(`TLM_OFF_LOW_EVEN, l0);
    wr(`TLM_OFF_LOW_ODD, l1);
    wr(`TLM_OFF_PAGE_MASK, m);
    op(32'h4);
  endtask
  task get(input logic [4:0] i, input logic [31:0] h, input logic [31:0] l0,
    input logic [31:0] l1, input logic [31:0] m);
    wr(`TLM_OFF_INDEX, {27'h0, i});
    op(32'h3);
    rd(`TLM_OFF_ENTRY_HIGH, rv);
    `CHK(rv, h);
    rd(`TLM_OFF_LOW_EVEN, rv);
    `CHK(rv, l0);
    rd(`TLM_OFF_LOW_ODD, rv);
    `CHK(rv, l1);
    rd(`TLM_OFF_PAGE_MASK, rv);
    `CHK(rv, m);
  endtask
  task look(input logic [18:0] v, input logic [7:0] a, input logic h, input logic [4:0] i);
    @(posedge clk);
    lookup_req <= 1'b1;
    lookup_virtual_page_pair_number <= v;
    lookup_address_space_id <= a;
    @(posedge clk);
    lookup_req <= 1'b0;
    @(negedge clk);
    `CHK(lookup_hit, h);
    if (h)
      `CHK(lookup_index, i);
  endtask
  task probe(input logic [31:0] h, input logic [31:0] exp_idx);
    wr(`TLM_OFF_ENTRY_HIGH, h);
    op(32'h2);
    rd(`TLM_OFF_INDEX, rv);
    `CHK(rv, exp_idx);
  endtask
  // Command with the status read strobed in the very next cycle, no gap between them.
  task cmd_stat(input logic [31:0] code, input logic [1:0] exp_stat);
    @(posedge clk);
    bus_req.addr <= `TLM_OFF_COMMAND;
    bus_req.wdata <= code;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    bus_req.addr <= `TLM_OFF_STATUS;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    `CHK(bus_rdata[1:0], exp_stat);
  endtask

  // Reset values, an unmapped read and a read of a never-written entry.
  task t_reset;
    rd(`TLM_OFF_CONFIG, rv);
    `CHK(rv, 32'h14);
    rd(8'h20, rv);
    `CHK(rv, 32'h0);
    get(5'd0, 32'h400, 32'h0, 32'h0, 32'h0);
  endtask
  // Masked page bits clear, global is the AND of both lows and comes back in both.
  task t_write_read;
    put(5'd3, hi_f(19'h12345, 8'h11), lo_f(21'h1abcd, 3'h3, 1'b1, 1'b1, 1'b1),
      lo_f(21'h0f0f3, 3'h5, 1'b0, 1'b1, 1'b0), 32'h6000);
    `CHK(mc_seen, 1'b0);
    get(5'd3, hi_f(19'h12344, 8'h11), lo_f(21'h1abcc, 3'h3, 1'b1, 1'b1, 1'b0),
      lo_f(21'h0f0f0, 3'h5, 1'b0, 1'b1, 1'b0), 32'h6000);
    put(5'd7, hi_f(19'h2aaaa, 8'h22), lo_f(21'h0, 3'h0, 1'b0, 1'b0, 1'b1),
      lo_f(21'h0, 3'h0, 1'b0, 1'b0, 1'b1), 32'h0);
    get(5'd7, hi_f(19'h2aaaa, 8'h22), 32'h1, 32'h1, 32'h0);
  endtask
  // Probe under the entry mask, by address space and by global, then a miss.
  task t_probe;
    probe(hi_f(19'h12347, 8'h11), 32'h3);
    probe(hi_f(19'h2aaaa, 8'h99), 32'h7);
    probe(hi_f(19'h12345, 8'h33), 32'h80000000);
    look(19'h12347, 8'h11, 1'b1, 5'd3);
  endtask
  // A duplicate write aborts with a machine check; the status shows it.
  task t_dup;
    put(5'd5, hi_f(19'h12345, 8'h11), 32'h0, 32'h0, 32'h0);
    `CHK(mc_seen, 1'b1);
    rd(`TLM_OFF_STATUS, rv);
    `CHK(rv[`TLM_STAT_MC_BIT], 1'b1);
    get(5'd5, 32'h400, 32'h0, 32'h0, 32'h0);
  endtask
  // Invalidate by write, then revive the entry with a normal write.
  task t_inval;
    put(5'd3, 32'h400, 32'h0, 32'h0, 32'h0);
    `CHK(mc_seen, 1'b0);
    look(19'h12347, 8'h11, 1'b0, 5'd0);
    get(5'd3, 32'h400, 32'h0, 32'h0, 32'h0);
    put(5'd3, hi_f(19'h12345, 8'h11), 32'h0, 32'h0, 32'h0);
    look(19'h12345, 8'h11, 1'b1, 5'd3);
  endtask
  // A write or a flush with coprocessor access off leaves the buffer unchanged.
  task t_cu;
    @(posedge clk);
    cp0_enable <= 1'b0;
    put(5'd3, hi_f(19'h00001, 8'h11), 32'h0, 32'h0, 32'h0);
    `CHK(cu_seen, 1'b1);
    `CHK(mc_seen, 1'b0);
    cmd_stat(32'h1, 2'b01);
    @(posedge clk);
    cp0_enable <= 1'b1;
    look(19'h12345, 8'h11, 1'b1, 5'd3);
  endtask
  // Flush ranges for each configuration.
  task t_flush;
    put(5'd16, hi_f(19'h01000, 8'h01), 32'h0, 32'h0, 32'h0);
    put(5'd18, hi_f(19'h02000, 8'h01), 32'h0, 32'h0, 32'h0);
    wr(`TLM_OFF_INDEX, 32'h10);
    op(32'h1);
    look(19'h01000, 8'h01, 1'b0, 5'd0);
    look(19'h02000, 8'h01, 1'b1, 5'd18);
    look(19'h12345, 8'h11, 1'b1, 5'd3);
    wr(`TLM_OFF_INDEX, 32'h0);
    op(32'h1);
    look(19'h12345, 8'h11, 1'b0, 5'd0);
    look(19'h02000, 8'h01, 1'b1, 5'd18);
    wr(`TLM_OFF_CONFIG, 32'h1c);
    op(32'h1);
    look(19'h02000, 8'h01, 1'b0, 5'd0);
    put(5'd3, hi_f(19'h12345, 8'h11), 32'h0, 32'h0, 32'h0);
    put(5'd18, hi_f(19'h02000, 8'h01), 32'h0, 32'h0, 32'h0);
    wr(`TLM_OFF_CONFIG, 32'h11);
    wr(`TLM_OFF_INDEX, 32'h12);
    op(32'h1);
    look(19'h12345, 8'h11, 1'b0, 5'd0);
    look(19'h02000, 8'h01, 1'b1, 5'd18);
  endtask
  // Two live entries answer one tag: the probe reports it only with r3 set.
  task t_multi;
    put(5'd20, hi_f(19'h03000, 8'h01), 32'h0, 32'h0, 32'h0);
    put(5'd21, hi_f(19'h03000, 8'h02), 32'h1, 32'h1, 32'h0);
    `CHK(mc_seen, 1'b0);
    wr(`TLM_OFF_ENTRY_HIGH, hi_f(19'h03000, 8'h01));
    cmd_stat(32'h2, 2'b00);
    wr(`TLM_OFF_CONFIG, 32'h34);
    cmd_stat(32'h2, 2'b10);
    rd(`TLM_OFF_INDEX, rv);
    `CHK(rv, 32'h15);
  endtask

  // Main sequence: reset for 20 cycles, then every scenario in turn.
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_write_read();
    t_probe();
    t_dup();
    t_inval();
    t_cu();
    t_flush();
    t_multi();
    close_out();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule // tlm_maint_test

bind tlm_maint tlm_maint_properties u_tlm_maint_properties (.clk(clk), .rst_b(rst_b),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .cp0_enable(cp0_enable),
  .lookup_req(lookup_req), .lookup_virtual_page_pair_number(lookup_virtual_page_pair_number), .lookup_address_space_id(lookup_address_space_id),
  .lookup_hit(lookup_hit), .lookup_index(lookup_index), .cop_unusable(cop_unusable),
  .machine_check(machine_check));

// file: include/tlm_defines.svh
// Constants for the translation buffer maintenance block: sizes, offsets, fields, resets.
`ifndef TLM_DEFINES_SVH
`define TLM_DEFINES_SVH
`define TLM_FIELD_A 16
`define TLM_FIX_WAYS 2
`define TLM_FIX_SETS 2
`define TLM_WAY_SHIFT 1
`define TLM_ENTRIES (`TLM_FIELD_A + (`TLM_FIX_WAYS + 2) * `TLM_FIX_SETS)
`define TLM_IDX_W 5
`define TLM_OFF_ENTRY_HIGH 8'h00
`define TLM_OFF_LOW_EVEN 8'h04
`define TLM_OFF_LOW_ODD 8'h08
`define TLM_OFF_PAGE_MASK 8'h0c
`define TLM_OFF_INDEX 8'h10
`define TLM_OFF_CONFIG 8'h14
`define TLM_OFF_COMMAND 8'h18
`define TLM_OFF_STATUS 8'h1c
`define TLM_HI_VPN_MSB 31
`define TLM_HI_VPN_LSB 13
`define TLM_HI_INV_BIT 10
`define TLM_HI_ADDRESS_SPACE_ID_MSB 7
`define TLM_LO_PFN_MSB 26
`define TLM_LO_PFN_LSB 6
`define TLM_LO_C_MSB 5
`define TLM_LO_C_LSB 3
`define TLM_LO_D_BIT 2
`define TLM_LO_V_BIT 1
`define TLM_LO_G_BIT 0
`define TLM_MASK_MSB 28
`define TLM_MASK_LSB 13
`define TLM_IDX_FAIL_BIT 31
`define TLM_CFG_MT_MSB 2
`define TLM_CFG_IE_MSB 4
`define TLM_CFG_IE_LSB 3
`define TLM_CFG_R3_BIT 5
`define TLM_MT_JOINT 3'h1
`define TLM_MT_VARFIX 3'h4
`define TLM_IE_SW 2'h2
`define TLM_IE_HW 2'h3
`define TLM_CFG_MT_RESET 3'h4
`define TLM_CFG_IE_RESET 2'h2
`define TLM_CFG_R3_RESET 1'b0
`define TLM_ENTRY_INV_RESET 1'b1
`define TLM_STAT_CU_BIT 0
`define TLM_STAT_MC_BIT 1
`endif

// file: include/tlm_pkg.sv
// Types shared by the translation buffer maintenance block.
package tlm_pkg;
  typedef enum logic [2:0] {
    TLM_OP_NONE = 3'b000,
    TLM_OP_FLUSH = 3'b001,
    TLM_OP_PROBE = 3'b010,
    TLM_OP_READ = 3'b011,
    TLM_OP_WRITE = 3'b100
  } tlm_op_t;

  typedef struct packed {
    logic inv;
    logic [15:0] mask;
    logic [18:0] virtual_page_pair_number;
    logic [7:0] address_space_id;
    logic g;
    logic [20:0] pfn0;
    logic [2:0] c0;
    logic d0;
    logic v0;
    logic [20:0] pfn1;
    logic [2:0] c1;
    logic d1;
    logic v1;
  } tlm_entry_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tlm_bus_req_t;

  typedef struct packed {
    logic [2:0] mt;
    logic [1:0] ie;
    logic r3;
  } tlm_cfg_t;
endpackage

// file: src/tlm_maint.sv
// Translation buffer maintenance: flush, probe, indexed read and indexed write.
//
// How it works
// [RULE1] Flush marks entries 0..field_a-1 invalid.
// [RULE2] Fixed-array index flushes only its set.
// [RULE3] Hardware walk flushes the whole extended range.
// [RULE4] Software keeps index in range for flush.
// [RULE5] Coprocessor disabled: exception, no buffer change.
// [RULE6] Probe loads index of masked matching entry.
// [RULE7] Probe miss sets index top bit.
// [RULE8] Multiple matches may raise machine check.
// [RULE9] Indexed read loads all staging registers.
// [RULE10] Reading invalid entry zeroes, sets invalidate flag.
// [RULE11] Read page and frame bits may be masked.
// [RULE12] Stored global bit returned in both lows.
// [RULE13] Staging registers packed with zero gaps.
// [RULE14] Normal indexed write stores all entry fields.
// [RULE15] Stored global is AND of both globals.
// [RULE16] Written page and frame bits may be masked.
// [RULE17] Invalidate write only sets the invalid marker.
// [RULE18] Invalid entries never match a translation.
// [RULE19] Normal write clears the invalid marker first.
// [RULE20] Duplicate match on write raises machine check.
// [RULE21] Software keeps index below entry count.
// [RULE22] Each operation completes in one cycle.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "tlm_defines.svh"

module tlm_maint
  import tlm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire tlm_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic cp0_enable,
  input wire logic lookup_req,
  input wire logic [18:0] lookup_virtual_page_pair_number,
  input wire logic [7:0] lookup_address_space_id,
  output logic lookup_hit,
  output logic [`TLM_IDX_W-1:0] lookup_index,
  output logic cop_unusable,
  output logic machine_check
);

  localparam int NUM_E = `TLM_ENTRIES;

  // Staging registers, configuration and the buffer array itself.
  logic [31:0] entry_high_reg_q;
  logic [31:0] entry_high_reg_d;
  logic [31:0] entry_low_even_reg_q;
  logic [31:0] entry_low_even_reg_d;
  logic [31:0] entry_low_odd_reg_q;
  logic [31:0] entry_low_odd_reg_d;
  logic [15:0] page_size_mask_reg_q;
  logic [15:0] page_size_mask_reg_d;
  logic [`TLM_IDX_W-1:0] index_q;
  logic [`TLM_IDX_W-1:0] index_d;
  logic index_fail_q;
  logic index_fail_d;
  tlm_cfg_t cfg_q;
  logic [1:0] status_q;
  logic [31:0] rdata_q;
  logic cu_q;
  logic mc_q;
  logic look_hit_q;
  logic [`TLM_IDX_W-1:0] look_idx_q;
  tlm_entry_t tlb_q [NUM_E];

  // Register decode; every register takes one aligned word.
  wire sel_hi = bus_req.addr == `TLM_OFF_ENTRY_HIGH;
  wire sel_lo0 = bus_req.addr == `TLM_OFF_LOW_EVEN;
  wire sel_lo1 = bus_req.addr == `TLM_OFF_LOW_ODD;
  wire sel_mask = bus_req.addr == `TLM_OFF_PAGE_MASK;
  wire sel_idx = bus_req.addr == `TLM_OFF_INDEX;
  wire sel_cfg = bus_req.addr == `TLM_OFF_CONFIG;
  wire sel_cmd = bus_req.addr == `TLM_OFF_COMMAND;
  wire sel_stat = bus_req.addr == `TLM_OFF_STATUS;

  // A command write issues one operation; an unknown code does nothing.
  wire cmd_wr = bus_req.wr & sel_cmd;
  wire [2:0] cmd_code = bus_req.wdata[2:0];
  wire op_any = cmd_wr & (cmd_code >= TLM_OP_FLUSH) & (cmd_code <= TLM_OP_WRITE);
  wire op_denied = op_any & ~cp0_enable; // [RULE5]
  wire op_ok = op_any & cp0_enable; // [RULE5]
  // An index past the array is undefined; clamping it to a no-op keeps the array safe.
  wire idx_in_range = {1'b0, index_q} < 6'(NUM_E); // [RULE21]
  wire do_flush = op_ok & (cmd_code == TLM_OP_FLUSH);
  wire do_probe = op_ok & (cmd_code == TLM_OP_PROBE);
  wire do_read = op_ok & (cmd_code == TLM_OP_READ) & idx_in_range;
  wire do_write = op_ok & (cmd_code == TLM_OP_WRITE) & idx_in_range;

  // Field views of the staging registers.
  wire [18:0] hi_virtual_page_pair_number = entry_high_reg_q[`TLM_HI_VPN_MSB:`TLM_HI_VPN_LSB];
  wire [7:0] hi_address_space_id = entry_high_reg_q[`TLM_HI_ADDRESS_SPACE_ID_MSB:0];
  wire hi_inv_flag = entry_high_reg_q[`TLM_HI_INV_BIT];
  wire ie_walk = (cfg_q.ie == `TLM_IE_SW) | (cfg_q.ie == `TLM_IE_HW);
  wire wr_inv_only = (cfg_q.ie > 2'h1) & hi_inv_flag; // [RULE17]
  wire [18:0] wr_mk19 = {3'h0, page_size_mask_reg_q};
  wire [20:0] wr_mk21 = {5'h00, page_size_mask_reg_q};
  wire [`TLM_IDX_W-1:0] idx_set = `TLM_IDX_W'((index_q - `TLM_IDX_W'(`TLM_FIELD_A))
    >> `TLM_WAY_SHIFT);

  // New entry built from the staging registers; masked bits are stored as zero.
  tlm_entry_t new_e;
  assign new_e.inv = 1'b0; // [RULE19]
  assign new_e.mask = page_size_mask_reg_q; // [RULE14]
  assign new_e.virtual_page_pair_number = hi_virtual_page_pair_number & ~wr_mk19; // [RULE16]
  assign new_e.address_space_id = hi_address_space_id; // [RULE14]
  assign new_e.g = entry_low_even_reg_q[`TLM_LO_G_BIT] & entry_low_odd_reg_q[`TLM_LO_G_BIT]; // [RULE15]
  assign new_e.pfn0 = entry_low_even_reg_q[`TLM_LO_PFN_MSB:`TLM_LO_PFN_LSB] & ~wr_mk21; // [RULE16]
  assign new_e.c0 = entry_low_even_reg_q[`TLM_LO_C_MSB:`TLM_LO_C_LSB];
  assign new_e.d0 = entry_low_even_reg_q[`TLM_LO_D_BIT];
  assign new_e.v0 = entry_low_even_reg_q[`TLM_LO_V_BIT];
  assign new_e.pfn1 = entry_low_odd_reg_q[`TLM_LO_PFN_MSB:`TLM_LO_PFN_LSB] & ~wr_mk21; // [RULE16]
  assign new_e.c1 = entry_low_odd_reg_q[`TLM_LO_C_MSB:`TLM_LO_C_LSB];
  assign new_e.d1 = entry_low_odd_reg_q[`TLM_LO_D_BIT];
  assign new_e.v1 = entry_low_odd_reg_q[`TLM_LO_V_BIT];

  // Per-entry comparators and flush range selection.
  logic [NUM_E-1:0] tag_hit;
  logic [NUM_E-1:0] look_vec;
  logic [NUM_E-1:0] flush_sel;
  logic [NUM_E-1:0] idx_onehot;
  // Duplicate detection: another live entry already answering the new tag.
  wire [NUM_E-1:0] dup_vec = tag_hit & ~idx_onehot;
  wire wr_dup = |dup_vec; // [RULE20]
  genvar gi;
  generate
    for (gi = 0; gi < NUM_E; gi++)
    begin : g_entry
      wire [18:0] mk = {3'h0, tlb_q[gi].mask};
      wire address_space_id_ok = tlb_q[gi].g | (tlb_q[gi].address_space_id == hi_address_space_id); // [RULE6]
      wire look_address_space_id_ok = tlb_q[gi].g | (tlb_q[gi].address_space_id == lookup_address_space_id);
      wire [`TLM_IDX_W-1:0] my_set = `TLM_IDX_W'((gi - `TLM_FIELD_A) >> `TLM_WAY_SHIFT);
      // Invalidated entries drop out of every comparison.
      assign tag_hit[gi] = ((tlb_q[gi].virtual_page_pair_number & ~mk) == (hi_virtual_page_pair_number & ~mk)) & address_space_id_ok
        & ~tlb_q[gi].inv; // [RULE6] [RULE18]
      assign look_vec[gi] = ((tlb_q[gi].virtual_page_pair_number & ~mk) == (lookup_virtual_page_pair_number & ~mk)) & look_address_space_id_ok
        & ~tlb_q[gi].inv; // [RULE18]
      assign idx_onehot[gi] = index_q == `TLM_IDX_W'(gi);
      assign flush_sel[gi] =
        ((cfg_q.mt == `TLM_MT_JOINT) & (gi < `TLM_FIELD_A)) | // [RULE1]
        ((cfg_q.mt == `TLM_MT_VARFIX) & (cfg_q.ie == `TLM_IE_SW)
          & (index_q < `TLM_IDX_W'(`TLM_FIELD_A)) & (gi < `TLM_FIELD_A)) | // [RULE1]
        ((cfg_q.mt == `TLM_MT_VARFIX) & (cfg_q.ie == `TLM_IE_SW)
          & (index_q >= `TLM_IDX_W'(`TLM_FIELD_A)) & (gi >= `TLM_FIELD_A)
          & (my_set == idx_set)) | // [RULE2]
        ((cfg_q.mt == `TLM_MT_VARFIX) & (cfg_q.ie == `TLM_IE_HW)
          & (gi <= `TLM_FIELD_A - 1 + (`TLM_FIX_WAYS + 2) * `TLM_FIX_SETS)); // [RULE3]

      // One entry of the array; flush and write never meet in one cycle.
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          tlb_q[gi] <= '{inv: `TLM_ENTRY_INV_RESET, default: '0};
        end
        else if (do_flush & flush_sel[gi])
        begin
          tlb_q[gi].inv <= 1'b1; // [RULE1] [RULE22]
        end
        else if (do_write & idx_onehot[gi] & wr_inv_only)
        begin
          tlb_q[gi].inv <= 1'b1; // [RULE17]
        end
        else if (do_write & idx_onehot[gi] & ~wr_dup)
        begin
          tlb_q[gi] <= new_e; // [RULE14] [RULE22]
        end
      end
    end
  endgenerate

  wire probe_multi = (tag_hit & (tag_hit - NUM_E'(1))) != '0; // [RULE8]
  wire probe_any = |tag_hit;
  wire look_any = |look_vec;

  // Highest matching entry wins, as the probe loop runs upward.
  logic [`TLM_IDX_W-1:0] probe_idx;
  logic [`TLM_IDX_W-1:0] look_idx;
  always_comb
  begin
    probe_idx = '0;
    look_idx = '0;
    for (int k = 0; k < NUM_E; k++)
    begin
      if (tag_hit[k])
      begin
        probe_idx = `TLM_IDX_W'(k); // [RULE6]
      end
      if (look_vec[k])
      begin
        look_idx = `TLM_IDX_W'(k);
      end
    end
  end

  // Indexed read view: masked fields, global copied into both low words.
  tlm_entry_t rd_e;
  assign rd_e = tlb_q[index_q];
  wire rd_inv = ie_walk & rd_e.inv; // [RULE10]
  wire [18:0] rd_mk19 = {3'h0, rd_e.mask};
  wire [20:0] rd_mk21 = {5'h00, rd_e.mask};
  wire [31:0] rd_hi = {rd_e.virtual_page_pair_number & ~rd_mk19, 5'h00, rd_e.address_space_id}; // [RULE11] [RULE13]
  wire [31:0] rd_lo0 = {5'h00, rd_e.pfn0 & ~rd_mk21, rd_e.c0, rd_e.d0, rd_e.v0,
    rd_e.g}; // [RULE12] [RULE13]
  wire [31:0] rd_lo1 = {5'h00, rd_e.pfn1 & ~rd_mk21, rd_e.c1, rd_e.d1, rd_e.v1,
    rd_e.g}; // [RULE12] [RULE13]
  wire [31:0] inv_hi = 32'h1 << `TLM_HI_INV_BIT;

  // Next values of the staging registers: software writes or operation results.
  always_comb
  begin
    entry_high_reg_d = entry_high_reg_q;
    entry_low_even_reg_d = entry_low_even_reg_q;
    entry_low_odd_reg_d = entry_low_odd_reg_q;
    page_size_mask_reg_d = page_size_mask_reg_q;
    index_d = index_q;
    index_fail_d = index_fail_q;
    if (bus_req.wr & sel_hi)
    begin
      entry_high_reg_d = bus_req.wdata;
    end
    if (bus_req.wr & sel_lo0)
    begin
      entry_low_even_reg_d = bus_req.wdata;
    end
    if (bus_req.wr & sel_lo1)
    begin
      entry_low_odd_reg_d = bus_req.wdata;
    end
    if (bus_req.wr & sel_mask)
    begin
      page_size_mask_reg_d = bus_req.wdata[`TLM_MASK_MSB:`TLM_MASK_LSB];
    end
    if (bus_req.wr & sel_idx)
    begin
      index_d = bus_req.wdata[`TLM_IDX_W-1:0];
      index_fail_d = bus_req.wdata[`TLM_IDX_FAIL_BIT];
    end
    if (do_probe)
    begin
      // Miss leaves the low bits cleared; they carry no meaning then.
      index_d = probe_any ? probe_idx : '0; // [RULE6] [RULE7]
      index_fail_d = ~probe_any; // [RULE7]
    end
    if (do_read & rd_inv)
    begin
      entry_high_reg_d = inv_hi; // [RULE10]
      entry_low_even_reg_d = '0; // [RULE10]
      entry_low_odd_reg_d = '0; // [RULE10]
      page_size_mask_reg_d = '0; // [RULE10]
    end
    else if (do_read)
    begin
      entry_high_reg_d = rd_hi; // [RULE9]
      entry_low_even_reg_d = rd_lo0; // [RULE9]
      entry_low_odd_reg_d = rd_lo1; // [RULE9]
      page_size_mask_reg_d = rd_e.mask; // [RULE9]
    end
  end

  // Machine check on a normal write with a duplicate, or on a probe with several matches when r3 is set.
  wire mc_now = (do_write & ~wr_inv_only & wr_dup) | (do_probe & cfg_q.r3 & probe_multi); // [RULE8] [RULE20]

  // Read mux; unmapped addresses read zero.
  wire [31:0] rd_mux =
    sel_hi ? entry_high_reg_q :
    sel_lo0 ? entry_low_even_reg_q :
    sel_lo1 ? entry_low_odd_reg_q :
    sel_mask ? {3'h0, page_size_mask_reg_q, 13'h0000} :
    sel_idx ? {index_fail_q, 26'h0000000, index_q} :
    sel_cfg ? {26'h0000000, cfg_q.r3, cfg_q.ie, cfg_q.mt} :
    sel_stat ? {30'h00000000, status_q} : 32'h00000000;

  // Staging registers and index.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      entry_high_reg_q <= '0;
      entry_low_even_reg_q <= '0;
      entry_low_odd_reg_q <= '0;
      page_size_mask_reg_q <= '0;
      index_q <= '0;
      index_fail_q <= 1'b0;
    end
    else
    begin
      entry_high_reg_q <= entry_high_reg_d;
      entry_low_even_reg_q <= entry_low_even_reg_d;
      entry_low_odd_reg_q <= entry_low_odd_reg_d;
      page_size_mask_reg_q <= page_size_mask_reg_d;
      index_q <= index_d;
      index_fail_q <= index_fail_d;
    end
  end

  // Configuration, written by software only.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg_q <= '{mt: `TLM_CFG_MT_RESET, ie: `TLM_CFG_IE_RESET, r3: `TLM_CFG_R3_RESET};
    end
    else if (bus_req.wr & sel_cfg)
    begin
      cfg_q <= '{mt: bus_req.wdata[`TLM_CFG_MT_MSB:0],
        ie: bus_req.wdata[`TLM_CFG_IE_MSB:`TLM_CFG_IE_LSB],
        r3: bus_req.wdata[`TLM_CFG_R3_BIT]};
    end
  end

  // Exception pulses, and the outcome of the last operation for software.
  // Status is overwritten by each operation, so no set and clear can collide.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cu_q <= 1'b0;
      mc_q <= 1'b0;
      status_q <= '0;
    end
    else
    begin
      cu_q <= op_denied; // [RULE5]
      mc_q <= mc_now;
      if (op_any)
      begin
        status_q <= {mc_now, op_denied};
      end
    end
  end

  // Translation lookup answer, one cycle after the request.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      look_hit_q <= 1'b0;
      look_idx_q <= '0;
    end
    else
    begin
      look_hit_q <= lookup_req & look_any; // [RULE18]
      look_idx_q <= lookup_req ? look_idx : look_idx_q;
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= bus_req.rd ? rd_mux : 32'h00000000;
    end
  end

  assign bus_rdata = rdata_q;
  assign lookup_hit = look_hit_q;
  assign lookup_index = look_idx_q;
  assign cop_unusable = cu_q;
  assign machine_check = mc_q;

endmodule // tlm_maint
